// [tpf_map.svh]
// constants of the packet framer: marker, fixed field values, sizes and register offsets
`ifndef TPF_MAP_SVH
`define TPF_MAP_SVH
`define TPF_SYNC_MARKER   32'h1ACFFC1D
`define TPF_IDENT_BASE    16'h880C
`define TPF_IDENT_MASK    16'hF80F
`define TPF_SEQ_INIT      16'hC000
`define TPF_LEN_MAX       9'h104
`define TPF_PKT_TYPE      32'h03000020
`define TPF_HOUSE_TAG     4'h2
`define TPF_CRC_INIT      16'hFFFF
`define TPF_CRC_POLY      16'h1021
`define TPF_SYNC_BYTES    9'h004
`define TPF_TX_HEAD_LAST  9'h015
`define TPF_RX_HEAD_LAST  9'h011
`define TPF_PAY_LAST      9'h104
`define TPF_PAY_BYTES     261
`define TPF_PWR_UNIT_A    7'h01
`define TPF_PWR_UNIT_B    7'h02
`define TPF_PWR_CODE_MAX  8'h0B
`define TPF_FIFO_DEPTH    32
`define TPF_REG_EXP       8'h00
`define TPF_REG_LEN       8'h04
`define TPF_REG_TIME0     8'h08
`define TPF_REG_TIME1     8'h0C
`define TPF_REG_DATA      8'h10
`define TPF_REG_CMD       8'h14
`define TPF_REG_STATUS    8'h18
`endif

// [tpf_pkg.sv]
// state types and the check-word step shared by both ends
`include "tpf_map.svh"
package tpf_pkg;
   typedef enum logic [2:0] {
      RX_HUNT  = 3'b000,
      RX_HEAD  = 3'b001,
      RX_PAY   = 3'b010,
      RX_CRC   = 3'b011,
      RX_CHECK = 3'b100,
      RX_FWD   = 3'b101
   } tpf_rx_state_e;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_HEAD = 2'b01,
      TX_PAY  = 2'b10,
      TX_CRC  = 2'b11
   } tpf_tx_state_e;

   // one byte into the check register, most significant bit first
   function automatic logic [15:0] crc_byte(input logic [7:0] b, input logic [15:0] c);
      logic [15:0] r;
      logic        fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         fb = r[15] ^ b[i];
         r  = {r[14:0], 1'b0};
         if (fb) begin
            r = r ^ `TPF_CRC_POLY;
         end
      end
      return r;
   endfunction : crc_byte
endpackage : tpf_pkg

// [tpf_link_if.sv]
// byte stream between the ground equipment and the onboard computer
interface tpf_link_if;
   logic [7:0] data;
   logic       valid;
   logic       ready;
   modport sender   (output data, output valid, input ready);
   modport receiver (input data, input valid, output ready);
endinterface : tpf_link_if

// [tpf_rx.sv]
// onboard end: hunts the marker, checks a command packet and hands it on
// Notes on behaviour
// - packets open with marker 1ACFFC1Dh
// - hunt for marker before reading fields
// - identifier is experiment times 16 plus 880Ch
// - sequence counts up from C000h; gaps reported
// - length is used bytes minus one, max 260
// - six timestamp bytes, sender fills them
// - timestamp contents ignored on receipt
// - packet type 3000020h, checked on receipt
// - housekeeping byte is task code plus 20h
// - 261 payload bytes, only used ones matter
// - experiment in bits 4-10, masked bits checked
// - trailing check word must match to execute
// - check register starts at all ones
// - data passes through, then check bits follow
// - check word low byte then high byte
// - units 1 and 2 are power switch
// - first payload byte picks on/off action
// - used payload forwarded unchanged to experiment
`include "tpf_map.svh"
module tpf_rx (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_B,
   // packet byte stream from the ground equipment
   tpf_link_if.receiver     LNK,
   // experiment command bytes, one per cycle
   output logic             FWD_VALID,
   output logic [6:0]       FWD_EXP,
   output logic [7:0]       FWD_BYTE,
   output logic             FWD_LAST,
   // power switch orders
   output logic             PWR_VALID,
   output logic [1:0]       PWR_UNIT,
   output logic [3:0]       PWR_CODE,
   // packet outcome
   output logic             CMD_OK,
   output logic             CMD_BAD,
   output logic             SEQ_GAP
);
   typedef struct packed {
      tpf_pkg::tpf_rx_state_e         state;
      logic [31:0]                    hunt;
      logic [8:0]                     idx;
      logic [143:0]                   head;
      logic [`TPF_PAY_BYTES-1:0][7:0] pay;
      logic [15:0]                    crc;
      logic [15:0]                    got_crc;
      logic [15:0]                    last_seq;
      logic                           seq_seen;
      logic                           rdy;
      logic                           fwd_valid;
      logic [6:0]                     fwd_exp;
      logic [7:0]                     fwd_byte;
      logic                           fwd_last;
      logic                           pwr_valid;
      logic [1:0]                     pwr_unit;
      logic [3:0]                     pwr_code;
      logic                           cmd_ok;
      logic                           cmd_bad;
      logic                           seq_gap;
   } tpf_rx_s;

   localparam tpf_rx_s RX_RESET = '{state: tpf_pkg::RX_HUNT, rdy: 1'b1, default: '0};

   tpf_rx_s     st;
   tpf_rx_s     next_st;
   logic        take;
   logic [31:0] hunt_win;
   logic [15:0] ident;
   logic [15:0] seq;
   logic [15:0] len;
   logic [31:0] ptype;
   logic [7:0]  house;
   logic [7:0]  sid;
   logic [6:0]  exp_num;
   logic        pkt_good;
   logic        is_pwr;
   logic        pwr_good;
   logic        seq_jump;

   // header fields as they sit in the collected header, first byte highest
   assign take     = LNK.valid && st.rdy;
   assign hunt_win = {st.hunt[23:0], LNK.data};
   assign ident    = st.head[143:128];
   assign seq      = st.head[127:112];
   assign len      = st.head[111:96];
   assign ptype    = st.head[47:16];                     // bits 95:48 hold the timestamp
   assign house    = st.head[15:8];
   assign sid      = st.head[7:0];
   assign exp_num  = ident[10:4];

   // validity of a whole packet and of a power order
   assign pkt_good = ((ident & `TPF_IDENT_MASK) == `TPF_IDENT_BASE)
                  && (ptype == `TPF_PKT_TYPE)
                  && (house[7:4] == `TPF_HOUSE_TAG)
                  && (len <= {7'h00, `TPF_LEN_MAX})
                  && (st.crc == st.got_crc);
   assign is_pwr   = (exp_num == `TPF_PWR_UNIT_A) || (exp_num == `TPF_PWR_UNIT_B);
   assign pwr_good = (sid == 8'h00) && (house[3:0] == 4'h0)
                  && (st.pay[0] <= `TPF_PWR_CODE_MAX);
   assign seq_jump = st.seq_seen && (seq != 16'(st.last_seq + 16'h0001));

   // next state of the receiver
   always_comb begin
      next_st           = st;
      next_st.fwd_valid = 1'b0;
      next_st.fwd_last  = 1'b0;
      next_st.pwr_valid = 1'b0;
      next_st.cmd_ok    = 1'b0;
      next_st.cmd_bad   = 1'b0;
      next_st.seq_gap   = 1'b0;
      case (st.state)
         tpf_pkg::RX_HUNT: begin
            if (take) begin
               next_st.hunt = hunt_win;
               if (hunt_win == `TPF_SYNC_MARKER) begin
                  next_st.state = tpf_pkg::RX_HEAD;
                  next_st.idx   = 9'h000;
                  next_st.hunt  = 32'h00000000;
                  next_st.crc   = `TPF_CRC_INIT;
               end
            end
         end
         tpf_pkg::RX_HEAD: begin
            if (take) begin
               next_st.head = {st.head[135:0], LNK.data};
               next_st.crc  = tpf_pkg::crc_byte(LNK.data, st.crc);
               if (st.idx == `TPF_RX_HEAD_LAST) begin
                  next_st.state = tpf_pkg::RX_PAY;
                  next_st.idx   = 9'h000;
               end else begin
                  next_st.idx = 9'(st.idx + 9'h001);
               end
            end
         end
         tpf_pkg::RX_PAY: begin
            if (take) begin
               next_st.pay[st.idx] = LNK.data;
               next_st.crc         = tpf_pkg::crc_byte(LNK.data, st.crc);
               if (st.idx == `TPF_PAY_LAST) begin
                  next_st.state = tpf_pkg::RX_CRC;
                  next_st.idx   = 9'h000;
               end else begin
                  next_st.idx = 9'(st.idx + 9'h001);
               end
            end
         end
         tpf_pkg::RX_CRC: begin
            if (take) begin
               if (st.idx == 9'h000) begin
                  next_st.got_crc[7:0] = LNK.data;
                  next_st.idx          = 9'h001;
               end else begin
                  next_st.got_crc[15:8] = LNK.data;
                  next_st.state         = tpf_pkg::RX_CHECK;
                  next_st.rdy           = 1'b0;
               end
            end
         end
         tpf_pkg::RX_CHECK: begin
            next_st.state = tpf_pkg::RX_HUNT;
            next_st.rdy   = 1'b1;
            next_st.idx   = 9'h000;
            if (!pkt_good) begin
               next_st.cmd_bad = 1'b1;
            end else begin
               next_st.seq_gap  = seq_jump;
               next_st.last_seq = seq;
               next_st.seq_seen = 1'b1;
               if (is_pwr) begin
                  next_st.cmd_ok    = pwr_good;
                  next_st.cmd_bad   = !pwr_good;
                  next_st.pwr_valid = pwr_good;
                  next_st.pwr_unit  = exp_num[1:0];
                  next_st.pwr_code  = st.pay[0][3:0];
               end else begin
                  next_st.cmd_ok = 1'b1;
                  next_st.state  = tpf_pkg::RX_FWD;
                  next_st.rdy    = 1'b0;
               end
            end
         end
         tpf_pkg::RX_FWD: begin
            next_st.fwd_valid = 1'b1;
            next_st.fwd_exp   = exp_num;
            next_st.fwd_byte  = st.pay[st.idx];
            next_st.fwd_last  = (st.idx == len[8:0]);
            if (st.idx == len[8:0]) begin
               next_st.state = tpf_pkg::RX_HUNT;
               next_st.rdy   = 1'b1;
               next_st.idx   = 9'h000;
            end else begin
               next_st.idx = 9'(st.idx + 9'h001);
            end
         end
         default: begin
            next_st = RX_RESET;
         end
      endcase
   end

   // state register
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         st <= RX_RESET;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign LNK.ready = st.rdy;
   assign FWD_VALID = st.fwd_valid;
   assign FWD_EXP   = st.fwd_exp;
   assign FWD_BYTE  = st.fwd_byte;
   assign FWD_LAST  = st.fwd_last;
   assign PWR_VALID = st.pwr_valid;
   assign PWR_UNIT  = st.pwr_unit;
   assign PWR_CODE  = st.pwr_code;
   assign CMD_OK    = st.cmd_ok;
   assign CMD_BAD   = st.cmd_bad;
   assign SEQ_GAP   = st.seq_gap;
endmodule : tpf_rx

// [tpf_tx.sv]
// ground end: payload fifo and packet builder driven by software over AHB-Lite
//
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`include "tpf_map.svh"
module tpf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `TPF_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic             CLK,
   input  wire logic             RST_B,
   // filling side
   input  wire logic             IN_VALID,
   input  wire logic [WIDTH-1:0] IN_DATA,
   output logic                  IN_READY,
   // draining side
   output logic                  OUT_VALID,
   output logic [WIDTH-1:0]      OUT_DATA,
   input  wire logic             OUT_READY
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
         $error("tpf_fifo: depth must be a power of two of at least 2");
      end
   endgenerate

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } tpf_fifo_s;

   tpf_fifo_s st;
   tpf_fifo_s next_st;
   logic      push;
   logic      pop;

   // full and empty follow the fill count
   assign IN_READY  = (st.cnt != (AW + 1)'(DEPTH));
   assign OUT_VALID = (st.cnt != '0);
   assign OUT_DATA  = st.mem[st.rp];
   assign push      = IN_VALID && IN_READY;
   assign pop       = OUT_VALID && OUT_READY;

   // pointer and count update
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.mem[st.wp] = IN_DATA;
         next_st.wp         = AW'(st.wp + 1'b1);
      end
      if (pop) begin
         next_st.rp = AW'(st.rp + 1'b1);
      end
      if (push && !pop) begin
         next_st.cnt = (AW + 1)'(st.cnt + 1'b1);
      end else if (pop && !push) begin
         next_st.cnt = (AW + 1)'(st.cnt - 1'b1);
      end
   end

   // state register
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule : tpf_fifo

module tpf_tx (
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_B,
   // AHB-Lite slave
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic             HREADYOUT,
   output logic [31:0]      HRDATA,
   output logic             HRESP,
   // packet byte stream to the onboard computer
   tpf_link_if.sender       LNK
);
   typedef struct packed {
      tpf_pkg::tpf_tx_state_e state;
      logic [8:0]             idx;
      logic [175:0]           hdr;
      logic [15:0]            crc;
      logic [15:0]            seq;
      logic [8:0]             len;
      logic [6:0]             exp;
      logic [3:0]             tsk;
      logic [7:0]             sid;
      logic [31:0]            tm0;
      logic [15:0]            tm1;
      logic                   pend;
      logic                   a_write;
      logic [7:0]             a_addr;
      logic                   hreadyout;
      logic [31:0]            hrdata;
      logic                   hresp;
      logic [7:0]             dat;
      logic                   val;
   } tpf_tx_s;

   localparam tpf_tx_s TX_RESET = '{state: tpf_pkg::TX_IDLE, seq: `TPF_SEQ_INIT,
                                    hreadyout: 1'b1, default: '0};

   tpf_tx_s     st;
   tpf_tx_s     next_st;
   logic        adv;
   logic        busy;
   logic [15:0] start_id;
   logic        f_push;
   logic        f_in_ready;
   logic        f_pop;
   logic        f_valid;
   logic [7:0]  f_data;
   logic        pay_used;
   logic        pay_ok;
   logic [7:0]  pay_byte;

   // payload bytes written by software wait here for the builder
   tpf_fifo #(.WIDTH(8), .DEPTH(`TPF_FIFO_DEPTH)) u_fifo (
      .CLK       (CLK),
      .RST_B     (RST_B),
      .IN_VALID  (f_push),
      .IN_DATA   (HWDATA[7:0]),
      .IN_READY  (f_in_ready),
      .OUT_VALID (f_valid),
      .OUT_DATA  (f_data),
      .OUT_READY (f_pop)
   );

   // helpers for the builder
   assign adv       = !st.val || LNK.ready;
   assign busy      = (st.state != tpf_pkg::TX_IDLE) || st.val;
   assign start_id  = 16'({5'h00, st.exp, 4'h0} + `TPF_IDENT_BASE);
   assign pay_used  = (st.idx <= st.len);
   assign pay_ok    = !pay_used || f_valid;
   assign pay_byte  = pay_used ? f_data : 8'h00;
   assign f_push    = st.pend && st.a_write && (st.a_addr == `TPF_REG_DATA);

   // link side builder, then the bus slave
   always_comb begin
      next_st = st;
      f_pop   = 1'b0;
      if (adv) begin
         next_st.val = 1'b0;
         case (st.state)
            tpf_pkg::TX_HEAD: begin
               next_st.val = 1'b1;
               next_st.dat = st.hdr[175:168];
               next_st.hdr = {st.hdr[167:0], 8'h00};
               if (st.idx >= `TPF_SYNC_BYTES) begin
                  next_st.crc = tpf_pkg::crc_byte(st.hdr[175:168], st.crc);
               end
               if (st.idx == `TPF_TX_HEAD_LAST) begin
                  next_st.state = tpf_pkg::TX_PAY;
                  next_st.idx   = 9'h000;
               end else begin
                  next_st.idx = 9'(st.idx + 9'h001);
               end
            end
            tpf_pkg::TX_PAY: begin
               if (pay_ok) begin
                  f_pop       = pay_used;
                  next_st.val = 1'b1;
                  next_st.dat = pay_byte;
                  next_st.crc = tpf_pkg::crc_byte(pay_byte, st.crc);
                  if (st.idx == `TPF_PAY_LAST) begin
                     next_st.state = tpf_pkg::TX_CRC;
                     next_st.idx   = 9'h000;
                  end else begin
                     next_st.idx = 9'(st.idx + 9'h001);
                  end
               end
            end
            tpf_pkg::TX_CRC: begin
               next_st.val = 1'b1;
               if (st.idx == 9'h000) begin
                  next_st.dat = st.crc[7:0];
                  next_st.idx = 9'h001;
               end else begin
                  next_st.dat   = st.crc[15:8];
                  next_st.state = tpf_pkg::TX_IDLE;
                  next_st.seq   = 16'(st.seq + 16'h0001);
               end
            end
            default: begin
            end
         endcase
      end
      if (st.pend) begin
         next_st.pend      = 1'b0;
         next_st.hreadyout = 1'b1;
         next_st.hrdata    = 32'h00000000;
         if (!st.a_write) begin
            if (st.a_addr == `TPF_REG_EXP) begin
               next_st.hrdata = {8'h00, st.sid, 4'h0, st.tsk, 1'b0, st.exp};
            end else if (st.a_addr == `TPF_REG_LEN) begin
               next_st.hrdata = {23'h000000, st.len};
            end else if (st.a_addr == `TPF_REG_TIME0) begin
               next_st.hrdata = st.tm0;
            end else if (st.a_addr == `TPF_REG_TIME1) begin
               next_st.hrdata = {16'h0000, st.tm1};
            end else if (st.a_addr == `TPF_REG_STATUS) begin
               next_st.hrdata = {st.seq, 15'h0000, busy};
            end
         end else if (st.a_addr == `TPF_REG_EXP) begin
            next_st.exp = HWDATA[6:0];
            next_st.tsk = HWDATA[11:8];
            next_st.sid = HWDATA[23:16];
         end else if (st.a_addr == `TPF_REG_LEN) begin
            next_st.len = (HWDATA[8:0] > `TPF_LEN_MAX) ? `TPF_LEN_MAX : HWDATA[8:0];
         end else if (st.a_addr == `TPF_REG_TIME0) begin
            next_st.tm0 = HWDATA;
         end else if (st.a_addr == `TPF_REG_TIME1) begin
            next_st.tm1 = HWDATA[15:0];
         end else if (st.a_addr == `TPF_REG_DATA) begin
            next_st.pend      = !f_in_ready;
            next_st.hreadyout = f_in_ready;
         end else if (st.a_addr == `TPF_REG_CMD) begin
            if (HWDATA[0] && st.state == tpf_pkg::TX_IDLE) begin
               next_st.state = tpf_pkg::TX_HEAD;
               next_st.idx   = 9'h000;
               next_st.crc   = `TPF_CRC_INIT;
               next_st.hdr   = {`TPF_SYNC_MARKER, start_id, st.seq,
                                7'h00, st.len, st.tm0[7:0], st.tm0[15:8],
                                st.tm0[23:16], st.tm0[31:24], st.tm1[7:0],
                                st.tm1[15:8], `TPF_PKT_TYPE,
                                `TPF_HOUSE_TAG, st.tsk, st.sid};
            end
         end
      end else if (HSEL && HTRANS[1] && HREADY) begin
         next_st.pend      = 1'b1;
         next_st.a_write   = HWRITE;
         next_st.a_addr    = HADDR[7:0];
         next_st.hreadyout = 1'b0;
      end
   end

   // state register
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         st <= TX_RESET;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign HREADYOUT = st.hreadyout;
   assign HRDATA    = st.hrdata;
   assign HRESP     = st.hresp;
   assign LNK.data  = st.dat;
   assign LNK.valid = st.val;
endmodule : tpf_tx

// [tpf_link_assertions.sv]
// link checker: marker, fixed header bytes and handshake between the two ends
`include "tpf_map.svh"
module tpf_link_assertions (
   // clock and reset
   input wire logic       CLK,
   input wire logic       RST_B,
   // link signals
   input wire logic [7:0] data,
   input wire logic       valid,
   input wire logic       ready
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] SYNC = `TPF_SYNC_MARKER;
   localparam logic [31:0] PTYP = `TPF_PKT_TYPE;
   logic       t;
   logic [8:0] n;
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // position of the taken byte within its packet
   assign t = valid && ready;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         n <= 9'h000;
      end else if (t) begin
         n <= (n == 9'h11C) ? 9'h000 : n + 9'h001;
      end
   end
   sync_order_a: assert property (t && n < 9'h004 |-> data == SYNC[31 - 8 * n -: 8])
      else $error("bad marker byte");
   ident_high_a: assert property (t && n == 9'h004 |-> data[7:3] == 5'h11)
      else $error("bad id high bits");
   ident_low_a: assert property (t && n == 9'h005 |-> data[3:0] == 4'hC)
      else $error("bad id low bits");
   len_high_a: assert property (t && n == 9'h008 |-> data[7:1] == 7'h00)
      else $error("length too big");
   type_field_a: assert property (t && n >= 9'h010 && n < 9'h014 |->
      data == PTYP[31 - 8 * (n - 9'h010) -: 8])
      else $error("bad type byte");
   house_tag_a: assert property (t && n == 9'h014 |-> data[7:4] == 4'h2)
      else $error("bad housekeeping tag");
   valid_hold_a: assert property (valid && !ready |=> valid && $stable(data))
      else $error("byte dropped before taken");
   check_pause_a: assert property (t && n == 9'h11C |=> !ready)
      else $error("no pause after check word");
endmodule : tpf_link_assertions

// [tb.sv]
// bench: software drives the ground end over AHB-Lite, onboard outputs are checked
`include "tpf_map.svh"
`define TB_CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CLK, RST_B, HSEL, HWRITE, HREADYOUT, HRESP, FWD_VALID, FWD_LAST;
   logic        PWR_VALID, CMD_OK, CMD_BAD, SEQ_GAP, bd, g, hav, ok, ak;
   logic [1:0]  HTRANS, PWR_UNIT, pu;
   logic [3:0]  PWR_CODE, pc;
   logic [6:0]  FWD_EXP, fx;
   logic [7:0]  FWD_BYTE;
   logic [15:0] sq, la;
   logic [31:0] HADDR, HWDATA, HRDATA, rd, tm;
   logic [7:0]  wq[$], got[$], want[$];
   int          num_errors, n_tests, cyc, ev;
   int          seed = 32'h7820;
   tpf_link_if  lnk ();
   tpf_tx u_tpf_tx (.CLK(CLK), .RST_B(RST_B), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
      .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
      .HREADYOUT(HREADYOUT), .HRDATA(HRDATA), .HRESP(HRESP), .LNK(lnk.sender));
   tpf_rx u_tpf_rx (.CLK(CLK), .RST_B(RST_B), .LNK(lnk.receiver), .FWD_VALID(FWD_VALID),
      .FWD_EXP(FWD_EXP), .FWD_BYTE(FWD_BYTE), .FWD_LAST(FWD_LAST), .PWR_VALID(PWR_VALID),
      .PWR_UNIT(PWR_UNIT), .PWR_CODE(PWR_CODE), .CMD_OK(CMD_OK), .CMD_BAD(CMD_BAD),
      .SEQ_GAP(SEQ_GAP));
   tpf_link_assertions u_tpf_link_assertions (.CLK(CLK), .RST_B(RST_B), .data(lnk.data),
      .valid(lnk.valid), .ready(lnk.ready));
   // 20 ns clock
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   // run ceiling, wire bytes, forwarded bytes and packet outcomes
   always @(posedge CLK) begin
      cyc++;
      if (lnk.valid && lnk.ready) wq.push_back(lnk.data);
      if (FWD_VALID) got.push_back(FWD_BYTE);
      if (FWD_VALID) fx = FWD_EXP;
      if (PWR_VALID) {pu, pc} = {PWR_UNIT, PWR_CODE};
      if (CMD_OK) {ak, g} = {1'b1, SEQ_GAP};
      if (CMD_BAD) bd = 1'b1;
      if (CMD_BAD || PWR_VALID || (FWD_VALID && FWD_LAST)) ev++;
      if (cyc == 60000) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic print_verdict();
      $display("tests %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict
   // check word, one byte msb first
   function automatic logic [15:0] crc(input logic [15:0] c, input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? 16'h1021 : 16'h0000);
      end
      return c;
   endfunction : crc
   // single word transfer; waits on the slave for both phases
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      {HSEL, HTRANS, HWRITE, HADDR} <= {1'b1, 2'h2, w, 24'h0, a};
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      {HSEL, HTRANS, HWDATA} <= {1'b0, 2'h0, d};
      do @(posedge CLK); while (HREADYOUT !== 1'b1);
      rd = HRDATA;
   endtask : xfer
   // one packet built by software, then its outcome at both ends
   task automatic pkt(input logic [6:0] e, input logic [3:0] tk, input logic [8:0] l,
                      input logic [7:0] b0);
      logic [15:0] c;
      int          k;
      k = ev;
      wq.delete();
      got.delete();
      want.delete();
      {ak, bd} = 2'b00;
      tm = $random(seed);
      ok = e > 7'h02 || (tk == 4'h0 && b0 < 8'h0C);
      xfer(1'b1, `TPF_REG_EXP, {20'h0, tk, 1'b0, e});
      xfer(1'b1, `TPF_REG_LEN, {23'h0, l});
      xfer(1'b1, `TPF_REG_TIME0, tm);
      // bytes queued ahead of the start fill the fifo on long packets
      for (int i = 0; i <= l; i++) begin
         want.push_back(i ? 8'($random(seed)) : b0);
         xfer(1'b1, `TPF_REG_DATA, {24'h0, want[i]});
         if (i == (l < 31 ? l : 31)) xfer(1'b1, `TPF_REG_CMD, 32'h1);
      end
      while (ev == k) @(posedge CLK);
      c = 16'hFFFF;
      for (int i = 4; i < 283; i++) c = crc(c, wq[i]);
      `TB_CHK({wq[284], wq[283]}, c)
      `TB_CHK({wq[4], wq[5]}, 16'h880C + e * 16)
      `TB_CHK({wq[6], wq[7]}, sq)
      `TB_CHK({wq[8], wq[9]}, {7'h0, l})
      `TB_CHK({wq[13], wq[12], wq[11], wq[10]}, tm)
      `TB_CHK({ak, bd}, {ok, !ok})
      if (e > 7'h02) begin
         `TB_CHK(fx, e)
         `TB_CHK(got.size(), l + 1)
         foreach (want[j]) `TB_CHK(got[j], want[j])
      end else if (ok) begin
         `TB_CHK({pu, pc}, {e[1:0], b0[3:0]})
      end else begin
         `TB_CHK(bd, 1'b1)
      end
      // the receiver tracks every packet whose header and check word pass
      if (ok) `TB_CHK(g, hav && sq != la + 16'h1)
      {hav, la} = {1'b1, sq};
      sq++;
   endtask : pkt
   // reset, status, power codes, bad orders, random and longest commands
   initial begin
      {HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
      {RST_B, sq, hav} = {1'b0, 16'hC000, 1'b0};
      repeat (10) @(posedge CLK);
      RST_B <= 1'b1;
      xfer(1'b0, `TPF_REG_STATUS, 32'h0);
      `TB_CHK({HRESP, rd}, {1'b0, 32'hC0000000})
      pkt(7'h0B, 4'h0, 9'h000, 8'h08);
      for (int c = 0; c < 14; c++) begin
         pkt(7'(1 + c % 2), 4'(c / 13), 9'({$random(seed)} % 5), 8'(c % 13));
      end
      for (int c = 0; c < 4; c++) begin
         pkt(7'(4 + {$random(seed)} % 8), 4'($random(seed)), 9'({$random(seed)} % 40),
             8'($random(seed)));
      end
      // next packet starts while the longest one is still being forwarded
      fork
         pkt(7'h04, 4'h1, 9'h104, 8'h55);
         begin
            @(posedge CLK iff CMD_OK);
            xfer(1'b1, `TPF_REG_EXP, 32'h00000005);
            xfer(1'b1, `TPF_REG_LEN, 32'h00000000);
            xfer(1'b1, `TPF_REG_DATA, 32'h000000A5);
            xfer(1'b1, `TPF_REG_CMD, 32'h00000001);
         end
      join
      while (got.size() < 262) @(posedge CLK);
      `TB_CHK({fx, got[261]}, {7'h05, 8'hA5})
      print_verdict();
   end
endmodule : tb
